/* File: logic/charge_time_pkg.sv */
// shared constants and types of the charge/time unit control block
// assumes one 40 MHz clock and a plain strobe register port
package charge_time_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_CTRL_HIGH = 4'h0;
  localparam logic [3:0] OFF_CTRL_LOW = 4'h1;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
  // control high fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_UNUSED6 = 6;
  localparam int BIT_IDLE_STOP = 5;
  localparam int BIT_DELAY_GEN = 4;
  localparam int BIT_EDGE_PASS = 3;
  localparam int BIT_EDGE_ORDER = 2;
  localparam int BIT_OUT_GROUND = 1;
  localparam int BIT_CONV_TRIG = 0;
  localparam logic [7:0] CTRL_HIGH_MASK = 8'hBF;
  localparam logic [7:0] CTRL_HIGH_RESET = 8'h00;
  // control low fields
  localparam int BIT_POL_B = 7;
  localparam int SEL_B_LSB = 5;
  localparam int BIT_POL_A = 4;
  localparam int SEL_A_LSB = 2;
  localparam int BIT_SEEN_B = 1;
  localparam int BIT_SEEN_A = 0;
  localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
  // interrupt status fields
  localparam int IRQ_CURRENT_OFF = 0;
  localparam int IRQ_EDGE_A = 1;
  localparam int IRQ_EDGE_B = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // source select codes
  localparam logic [1:0] SRC_PIN_A = 2'h3;
  localparam logic [1:0] SRC_PIN_B = 2'h2;
  localparam logic [1:0] SRC_CMP_A = 2'h1;
  localparam logic [1:0] SRC_CMP_B = 2'h0;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic cmp_a;
    logic cmp_b;
  } edge_src_t;

  typedef struct packed {
    logic current_on;
    logic current_ground;
    logic delay_gen;
    logic conv_trigger;
  } analog_ctl_t;
endpackage

/* File: logic/level_sync.sv */
// three stage synchroniser with agreement filter
// assumes async input and one clock with enable
module level_sync
  #(parameter int STAGES = 3)
  (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic async_in,
  output logic level_out
  );
  logic [STAGES-1:0] chain_r;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      chain_r <= '0;
    else if (ce_in)
      chain_r <= {chain_r[STAGES-2:0], async_in};
  end

  // level moves only when last two stages agree
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      level_out <= 1'b0;
    else if (ce_in && (chain_r[STAGES-1] == chain_r[STAGES-2]))
      level_out <= chain_r[STAGES-1];
  end
endmodule

/* File: logic/charge_time_unit.sv */
// control logic of the charge/time measurement unit
// assumes a strobe register master on clk_in, edge pins asynchronous,
// compare triggers already on clk_in
//
// Notes on behaviour
// - top bit enables edge capture and delay output only
// - bit six reads zero, ignores writes
// - idle-stop bit suspends unit during idle
// - delay generation bit drives delay enable
// - edge-pass bit blocks or passes edges
// - ordered mode needs edge one first
// - ground bit grounds current output
// - lowest bit gates converter trigger output
// - enabled trigger lets special event start conversion
// - reset clears all control bits
// - channels respond to level of source
// - select 11 pinA, 10 pinB, 01 cmpA, 00 cmpB
// - status bit sets when level matches while its seen bit is still clear
// - current on while exactly one seen bit
// - flag raised when current turns off
module charge_time_unit
  (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire charge_time_pkg::reg_req_t req_in,
  output logic [charge_time_pkg::DATA_W-1:0] rdata_out,
  input wire logic edge_pin_a_in,
  input wire logic edge_pin_b_in,
  input wire logic compare_unit_a_in,
  input wire logic compare_unit_b_in,
  input wire logic idle_mode_in,
  output charge_time_pkg::analog_ctl_t analog_out,
  output logic irq_out
  );
  import charge_time_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] ctrl_high_r;
  logic [7:0] ctrl_low_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic pin_a_sync;
  logic pin_b_sync;
  edge_src_t src;
  logic level_a;
  logic level_b;
  logic active;
  logic hit_a;
  logic hit_b;
  logic seen_a_nxt;
  logic seen_b_nxt;
  logic current_on;
  logic current_on_r;
  logic current_off_evt;
  logic wr_high;
  logic wr_low;
  logic rd_status;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  level_sync #(.STAGES(SYNC_STAGES)) u_sync_a
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(edge_pin_a_in),
    .level_out(pin_a_sync)
  );

  level_sync #(.STAGES(SYNC_STAGES)) u_sync_b
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(edge_pin_b_in),
    .level_out(pin_b_sync)
  );

  assign src = '{pin_a: pin_a_sync, pin_b: pin_b_sync,
                 cmp_a: compare_unit_a_in, cmp_b: compare_unit_b_in};

  ////////////////////////////////////////////////////////////////////
  // source select and polarity
  function automatic logic pick(input edge_src_t s, input logic [1:0] sel);
    logic v;
    v = 1'b0;
    unique case (sel)
      SRC_PIN_A: v = s.pin_a;
      SRC_PIN_B: v = s.pin_b;
      SRC_CMP_A: v = s.cmp_a;
      SRC_CMP_B: v = s.cmp_b;
    endcase
    return v;
  endfunction

  // level, not transition, with polarity applied
  assign level_a = pick(src, ctrl_low_r[SEL_A_LSB+:2]) == ctrl_low_r[BIT_POL_A];
  assign level_b = pick(src, ctrl_low_r[SEL_B_LSB+:2]) == ctrl_low_r[BIT_POL_B];

  // unit running: enabled, not stopped by idle
  assign active = ctrl_high_r[BIT_ENABLE]
    && !(ctrl_high_r[BIT_IDLE_STOP] && idle_mode_in);

  assign hit_a = active && ctrl_high_r[BIT_EDGE_PASS] && level_a;
  // ordered mode: second channel needs first seen
  assign hit_b = active && ctrl_high_r[BIT_EDGE_PASS] && level_b
    && (!ctrl_high_r[BIT_EDGE_ORDER] || ctrl_low_r[BIT_SEEN_A]);

  assign wr_high = req_in.wr && (req_in.addr == OFF_CTRL_HIGH);
  assign wr_low = req_in.wr && (req_in.addr == OFF_CTRL_LOW);
  assign rd_status = req_in.rd && (req_in.addr == OFF_IRQ_STATUS);

  ////////////////////////////////////////////////////////////////////
  // control high register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_high_r <= CTRL_HIGH_RESET;
    else if (ce_in && wr_high)
      ctrl_high_r <= req_in.wdata & CTRL_HIGH_MASK;
  end

  ////////////////////////////////////////////////////////////////////
  // control low register with seen bits; hardware set wins
  always_comb
  begin
    seen_a_nxt = ctrl_low_r[BIT_SEEN_A];
    seen_b_nxt = ctrl_low_r[BIT_SEEN_B];
    if (wr_low)
    begin
      seen_a_nxt = req_in.wdata[BIT_SEEN_A];
      seen_b_nxt = req_in.wdata[BIT_SEEN_B];
    end
    if (hit_a)
      seen_a_nxt = 1'b1;
    if (hit_b)
      seen_b_nxt = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_low_r <= CTRL_LOW_RESET;
    else if (ce_in)
    begin
      if (wr_low)
        ctrl_low_r[7:2] <= req_in.wdata[7:2];
      ctrl_low_r[BIT_SEEN_A] <= seen_a_nxt;
      ctrl_low_r[BIT_SEEN_B] <= seen_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // current source and off event
  assign current_on = ctrl_low_r[BIT_SEEN_A] ^ ctrl_low_r[BIT_SEEN_B];

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      current_on_r <= 1'b0;
    else if (ce_in)
      current_on_r <= current_on;
  end

  assign current_off_evt = current_on_r && !current_on;

  ////////////////////////////////////////////////////////////////////
  // analog control outputs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      analog_out <= '0;
    else if (ce_in)
    begin
      analog_out.current_on <= current_on;
      analog_out.current_ground <= ctrl_high_r[BIT_OUT_GROUND];
      analog_out.delay_gen <= ctrl_high_r[BIT_DELAY_GEN] && active;
      // special event pulse to converter when enabled
      analog_out.conv_trigger <= ctrl_high_r[BIT_CONV_TRIG] && current_off_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status and mask; set beats read clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_status_r <= IRQ_RESET;
    else if (ce_in)
    begin
      irq_status_r <= (rd_status ? IRQ_RESET : irq_status_r)
        | {hit_b && !ctrl_low_r[BIT_SEEN_B], hit_a && !ctrl_low_r[BIT_SEEN_A],
           current_off_evt};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_mask_r <= IRQ_RESET;
    else if (ce_in && req_in.wr && (req_in.addr == OFF_IRQ_MASK))
      irq_mask_r <= req_in.wdata[IRQ_W-1:0];
  end

  assign irq_out = |(irq_status_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (ce_in)
    begin
      rdata_out <= 8'h00;
      if (req_in.rd)
      begin
        unique case (req_in.addr)
          OFF_CTRL_HIGH: rdata_out <= ctrl_high_r;
          OFF_CTRL_LOW: rdata_out <= ctrl_low_r;
          OFF_IRQ_STATUS: rdata_out <= {5'h00, irq_status_r};
          OFF_IRQ_MASK: rdata_out <= {5'h00, irq_mask_r};
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions
  property p_bit6_zero;
    @(posedge clk_in) disable iff (rst_in) ctrl_high_r[BIT_UNUSED6] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit six set");

  property p_reset_clear;
    @(posedge clk_in) rst_in |=> (ctrl_high_r == 8'h00 && !analog_out.current_on);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left bits");

  property p_current_xor;
    @(posedge clk_in) disable iff (rst_in)
      ce_in |=> analog_out.current_on == $past(ctrl_low_r[1] ^ ctrl_low_r[0]);
  endproperty
  a_current_xor: assert property (p_current_xor) else $error("current wrong");

  property p_no_edge_disabled;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && !ctrl_high_r[BIT_ENABLE] && !wr_low) |=> $stable(ctrl_low_r[1:0]);
  endproperty
  a_no_edge_disabled: assert property (p_no_edge_disabled) else $error("edge while off");

  property p_blocked;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && !ctrl_high_r[BIT_EDGE_PASS] && !wr_low) |=> $stable(ctrl_low_r[1:0]);
  endproperty
  a_blocked: assert property (p_blocked) else $error("edge passed blocked");

  property p_order;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && !wr_low && ctrl_high_r[BIT_EDGE_ORDER] && !ctrl_low_r[0] && !ctrl_low_r[1])
      |=> !ctrl_low_r[1];
  endproperty
  a_order: assert property (p_order) else $error("order broken");

  property p_level_sets;
    @(posedge clk_in) disable iff (rst_in) (ce_in && hit_a) |=> ctrl_low_r[0];
  endproperty
  a_level_sets: assert property (p_level_sets) else $error("seen not set");

  property p_off_flag;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && current_on_r && !current_on) |=> irq_status_r[IRQ_CURRENT_OFF];
  endproperty
  a_off_flag: assert property (p_off_flag) else $error("no off flag");

  property p_ground;
    @(posedge clk_in) disable iff (rst_in)
      ce_in |=> analog_out.current_ground == $past(ctrl_high_r[BIT_OUT_GROUND]);
  endproperty
  a_ground: assert property (p_ground) else $error("ground wrong");

  property p_trig_gated;
    @(posedge clk_in) disable iff (rst_in)
      analog_out.conv_trigger |-> $past(ctrl_high_r[BIT_CONV_TRIG]);
  endproperty
  a_trig_gated: assert property (p_trig_gated) else $error("trigger ungated");

  property p_delay_gen;
    @(posedge clk_in) disable iff (rst_in)
      ce_in |=> analog_out.delay_gen == $past(ctrl_high_r[BIT_DELAY_GEN]
        && ctrl_high_r[BIT_ENABLE] && !(ctrl_high_r[BIT_IDLE_STOP] && idle_mode_in));
  endproperty
  a_delay_gen: assert property (p_delay_gen) else $error("delay enable wrong");

  property p_idle_hold;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && ctrl_high_r[BIT_IDLE_STOP] && idle_mode_in && !wr_low)
      |=> $stable(ctrl_low_r[BIT_SEEN_B:BIT_SEEN_A]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("edge while idle stopped");

  property p_trig_fires;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && ctrl_high_r[BIT_CONV_TRIG] && current_off_evt) |=> analog_out.conv_trigger;
  endproperty
  a_trig_fires: assert property (p_trig_fires) else $error("trigger missing");

  property p_pin_a_level;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && active && ctrl_high_r[BIT_EDGE_PASS]
        && ctrl_low_r[SEL_A_LSB+:2] == SRC_PIN_A && pin_a_sync == ctrl_low_r[BIT_POL_A])
      |=> ctrl_low_r[BIT_SEEN_A];
  endproperty
  a_pin_a_level: assert property (p_pin_a_level) else $error("pin source missed");

  property p_cmp_a_level;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && active && ctrl_high_r[BIT_EDGE_PASS] && ctrl_low_r[SEL_A_LSB+:2] == SRC_CMP_A
        && compare_unit_a_in == ctrl_low_r[BIT_POL_A])
      |=> ctrl_low_r[BIT_SEEN_A];
  endproperty
  a_cmp_a_level: assert property (p_cmp_a_level) else $error("level not seen");

  property p_b_sets;
    @(posedge clk_in) disable iff (rst_in) (ce_in && hit_b) |=> ctrl_low_r[BIT_SEEN_B];
  endproperty
  a_b_sets: assert property (p_b_sets) else $error("second seen not set");

  property p_status_clear;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && rd_status && !current_off_evt && !hit_a && !hit_b)
      |=> irq_status_r == IRQ_RESET;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_read_bit6;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && req_in.rd && req_in.addr == OFF_CTRL_HIGH) |=> !rdata_out[BIT_UNUSED6];
  endproperty
  a_read_bit6: assert property (p_read_bit6) else $error("bit six read set");

  c_idle_stop: cover property (@(posedge clk_in) disable iff (rst_in)
    ctrl_high_r[BIT_IDLE_STOP] && idle_mode_in);
  c_current_on: cover property (@(posedge clk_in) disable iff (rst_in)
    analog_out.current_on);
  c_conv: cover property (@(posedge clk_in) disable iff (rst_in) analog_out.conv_trigger);
  c_irq: cover property (@(posedge clk_in) disable iff (rst_in) irq_out);
endmodule

/* File: tb/edge_source_model.sv */
// far side model: edge pins, compare triggers and converter pulse counter
// assumes the bench commands source levels, one bit per select code
module edge_source_model
  (
  input wire logic clk_in,
  input wire logic [3:0] level_cmd_in,
  input wire logic conv_trigger_in,
  output logic pin_a_out,
  output logic pin_b_out,
  output logic cmp_a_out,
  output logic cmp_b_out,
  output int conv_count_out
  );
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] level_r = 4'h0;
  int count_r = 0;

  always @(posedge clk_in)
  begin
    level_r <= level_cmd_in;
    if (conv_trigger_in === 1'b1)
      count_r <= count_r + 1;
  end

  assign {pin_a_out, pin_b_out, cmp_a_out, cmp_b_out} = level_r;
  assign conv_count_out = count_r;
endmodule

/* File: tb/tb_charge_time_unit.sv */
// self-checking bench of the charge/time unit control
// assumes edge_source_model as far side, one 40 MHz clock
module tb_charge_time_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import charge_time_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1;
  logic idle_mode = 1'b0;
  logic [3:0] level_cmd = 4'h0;
  reg_req_t req = '0;
  logic [7:0] rdata;
  analog_ctl_t analog;
  logic irq, pin_a, pin_b, cmp_a, cmp_b;
  int conv_count;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  initial forever #12.5 clk_in = ~clk_in;

  charge_time_unit DUT
    (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce),
    .req_in(req),
    .rdata_out(rdata),
    .edge_pin_a_in(pin_a),
    .edge_pin_b_in(pin_b),
    .compare_unit_a_in(cmp_a),
    .compare_unit_b_in(cmp_b),
    .idle_mode_in(idle_mode),
    .analog_out(analog),
    .irq_out(irq)
    );

  edge_source_model far_side
    (
    .clk_in(clk_in),
    .level_cmd_in(level_cmd),
    .conv_trigger_in(analog.conv_trigger),
    .pin_a_out(pin_a),
    .pin_b_out(pin_b),
    .cmp_a_out(cmp_a),
    .cmp_b_out(cmp_b),
    .conv_count_out(conv_count)
    );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_bits;
    wr(OFF_CTRL_HIGH, 8'hFF);
    rd(OFF_CTRL_HIGH, CTRL_HIGH_MASK, "ctrl high");
    chk("ground", 8'h01, {7'h0, analog.current_ground});
    chk("delay gen", 8'h01, {7'h0, analog.delay_gen});
    wr(OFF_CTRL_HIGH, 8'h00);
    wait_clk(3);
    chk("ground off", 8'h00, {7'h0, analog.current_ground});
  endtask

  task automatic t_measure(input logic [7:0] ctrl, input int pulses);
    int base;
    base = conv_count;
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_CTRL_LOW, 8'h94);
    wr(OFF_CTRL_HIGH, ctrl);
    level_cmd <= 4'h2;
    wait_clk(4);
    chk("current on", 8'h01, {7'h0, analog.current_on});
    rd(OFF_CTRL_LOW, 8'h95, "seen a");
    @(posedge clk_in);
    level_cmd <= 4'h3;
    wait_clk(4);
    chk("current off", 8'h00, {7'h0, analog.current_on});
    chk("irq", 8'h01, {7'h0, irq});
    chk("conversions", 8'(pulses), 8'(conv_count - base));
    rd(OFF_IRQ_STATUS, 8'h07, "status");
    chk("irq cleared", 8'h00, {7'h0, irq});
    @(posedge clk_in);
    level_cmd <= 4'h0;
    wait_clk(2);
    wr(OFF_CTRL_LOW, 8'h94);
  endtask

  task automatic t_gate(input logic [7:0] ctrl, input logic [7:0] exp);
    wr(OFF_CTRL_HIGH, ctrl);
    wr(OFF_CTRL_LOW, 8'h94);
    level_cmd <= 4'h2;
    wait_clk(4);
    rd(OFF_CTRL_LOW, exp, "gated seen");
    @(posedge clk_in);
    level_cmd <= 4'h0;
    wait_clk(2);
    wr(OFF_CTRL_LOW, 8'h94);
  endtask

  task automatic t_select;
    logic [7:0] low;
    wr(OFF_CTRL_HIGH, 8'h8C);
    for (int s = 3; s >= 0; s--)
    begin
      low = 8'h90 | 8'(s << 2);
      wr(OFF_CTRL_LOW, low);
      level_cmd <= ~(4'h1 << s);
      wait_clk(8);
      rd(OFF_CTRL_LOW, low, "unselected");
      @(posedge clk_in);
      level_cmd <= 4'h1 << s;
      wait_clk(8);
      rd(OFF_CTRL_LOW, low | 8'h01 | ((s == 0) ? 8'h02 : 8'h00), "selected");
      @(posedge clk_in);
      level_cmd <= 4'h0;
      wait_clk(8);
      wr(OFF_CTRL_LOW, low);
    end
  endtask

  task automatic t_freeze;
    @(posedge clk_in);
    ce <= 1'b0;
    level_cmd <= 4'h1;
    wait_clk(4);
    @(posedge clk_in);
    level_cmd <= 4'h0;
    wait_clk(2);
    @(posedge clk_in);
    ce <= 1'b1;
    rd(OFF_CTRL_LOW, 8'h90, "frozen seen");
  endtask

  task automatic t_reset;
    wr(OFF_CTRL_HIGH, 8'hBF);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(OFF_CTRL_HIGH, CTRL_HIGH_RESET, "ctrl high rst");
    rd(OFF_CTRL_LOW, CTRL_LOW_RESET, "ctrl low rst");
    chk("analog rst", 8'h00, {4'h0, analog});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(OFF_CTRL_HIGH, CTRL_HIGH_RESET, "ctrl high reset");
    chk("analog reset", 8'h00, {4'h0, analog});
    rd(4'h9, 8'h00, "unmapped");
    t_bits();
    t_measure(8'h89, 1);
    t_measure(8'h88, 0);
    t_gate(8'h08, 8'h94);
    t_gate(8'h80, 8'h94);
    idle_mode <= 1'b1;
    t_gate(8'hA8, 8'h94);
    t_gate(8'h88, 8'h95);
    idle_mode <= 1'b0;
    t_select();
    t_freeze();
    wr(OFF_CTRL_HIGH, 8'h00);
    wr(OFF_CTRL_LOW, 8'h96);
    rd(OFF_CTRL_LOW, 8'h96, "software seen");
    t_reset();
    report_and_stop();
  end
endmodule
